// file: src/cef_consts.vh
`ifndef CEF_CONSTS_VH
`define CEF_CONSTS_VH

// Register offsets
`define CEF_OFS_ID     8'h00
`define CEF_OFS_FLAG_A 8'h01
`define CEF_OFS_FLAG_B 8'h02
`define CEF_OFS_FLAG_C 8'h03
`define CEF_OFS_STATE  8'h04
`define CEF_OFS_MASK_A 8'h05
`define CEF_OFS_MASK_B 8'h06
`define CEF_OFS_MASK_C 8'h07

// Bit positions in event_flags_a
`define CEF_A_CONV_OCP  7
`define CEF_A_FLY_SHORT 6
`define CEF_A_OUT_PRES  5
`define CEF_A_IN_LOW    4
`define CEF_A_OUT_SHORT 3
`define CEF_A_WL_PRES   2
`define CEF_A_SW_START  1
`define CEF_A_IN_PRES   0

// Reset values and reserved readback
`define CEF_MASK_A_RST 8'hff
`define CEF_MASK_B_RST 5'h1f
`define CEF_MASK_C_RST 2'h3
`define CEF_RSVD_MB    3'h7
`define CEF_RSVD_MC    6'h3f
`define CEF_STATE_RST  3'h0
`define CEF_FLAG_A_REG_CLR 8'h01

// Converter state codes
`define CEF_ST_PRESENT   3'h0
`define CEF_ST_STANDBY   3'h1
`define CEF_ST_FWD_HALV  3'h2
`define CEF_ST_FWD_BYP   3'h3
`define CEF_ST_REV_HALV  3'h4
`define CEF_ST_REV_BYP   3'h5
`define CEF_ST_FAULT     3'h6

// Serial port slave address
`define CEF_I2C_ADDR 7'h66

`endif

// file: src/cef_flag_bank.v
`timescale 1ns/1ps
module cef_flag_bank #(
  parameter WIDTH = 8
) (
  input  wire             clk,
  input  wire             nrst,
  input  wire [WIDTH-1:0] evt,
  input  wire             rdClr,
  input  wire             regClr,
  input  wire [WIDTH-1:0] regClrSel,
  output wire [WIDTH-1:0] flags
);

  reg  [WIDTH-1:0] evtPrev_q;
  reg  [WIDTH-1:0] flags_q;
  wire [WIDTH-1:0] rise;
  wire [WIDTH-1:0] clrMask;

  // Flags catch the rising edge so a lasting fault raises one request only
  assign rise    = evt & ~evtPrev_q;
  assign clrMask = {WIDTH{rdClr}} | ({WIDTH{regClr}} & regClrSel);
  assign flags   = flags_q;

  ////////////////////////////////////////////////////////////////////////
  // Sticky flags; a new edge wins over a clear in the same cycle
  always @(posedge clk) begin
    if (!nrst) begin
      evtPrev_q <= {WIDTH{1'b0}};
      flags_q   <= {WIDTH{1'b0}};
    end else begin
      evtPrev_q <= evt;
      flags_q   <= rise | (flags_q & ~clrMask);
    end
  end

endmodule // cef_flag_bank

// file: src/cef_event_regs.v
`timescale 1ns/1ps
`include "cef_consts.vh"
module cef_event_regs #(
  parameter [3:0] REVISION = 4'h1, // Arbitrary value
  parameter [3:0] PART_ID  = 4'h5  // Arbitrary value
) (
  input  wire       clk,
  input  wire       nrst,
  input  wire       sclIn,
  input  wire       sdaIn,
  output wire       sdaOut,
  output wire       sdaOeN,
  input  wire       regRst,
  input  wire       stateLoad,
  input  wire [2:0] stateIn,
  input  wire       converterOvercurrent,
  input  wire       flyingCapShortCheck,
  input  wire       outputPresent,
  input  wire       inputTooLow,
  input  wire       outputShort,
  input  wire       wirelessInputPresent,
  input  wire       switchingStarted,
  input  wire       inputPresent,
  input  wire       inputOvervoltage,
  input  wire       outputOvervoltage,
  input  wire       overtempRelease,
  input  wire       dieOvertemp,
  input  wire       watchdogTimeout,
  input  wire       inputOvercurrent,
  input  wire       reverseWirelessOvercurrent,
  output wire       irqN
);

  // Serial slave states
  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_ADDR  = 3'h1;
  localparam [2:0] ST_ACK   = 3'h2;
  localparam [2:0] ST_PTR   = 3'h3;
  localparam [2:0] ST_WDATA = 3'h4;
  localparam [2:0] ST_RDATA = 3'h5;
  localparam [2:0] ST_RACK  = 3'h6;
  localparam [2:0] ST_RLOAD = 3'h7;

  reg        sclPrev_q;
  reg        sdaPrev_q;
  reg  [2:0] st_q;
  reg  [2:0] st_d;
  reg  [2:0] bitCnt_q;
  reg  [2:0] bitCnt_d;
  reg  [7:0] shift_q;
  reg  [7:0] shift_d;
  reg  [7:0] ptr_q;
  reg  [7:0] ptr_d;
  reg        drive_q;
  reg        drive_d;
  reg  [2:0] ackNext_q;
  reg  [2:0] ackNext_d;
  reg        wrEn;
  reg        loadNow;
  reg  [7:0] rdData;
  reg  [7:0] maskA_q;
  reg  [4:0] maskB_q;
  reg  [1:0] maskC_q;
  reg  [2:0] state_q;
  reg        otArmed_q;
  reg        irqN_q;
  wire       sclRise;
  wire       sclFall;
  wire       startDet;
  wire       stopDet;
  wire [7:0] shiftIn;
  wire       halvFwd;
  wire       halvRev;
  wire       bypFwd;
  wire       relEvt;
  wire [7:0] evtA;
  wire [4:0] evtB;
  wire [1:0] evtC;
  wire [7:0] flagA;
  wire [4:0] flagB;
  wire [1:0] flagC;
  wire       pend;

  ////////////////////////////////////////////////////////////////////////
  // Bus line edges; pins arrive already synchronous to clk
  always @(posedge clk) begin
    if (!nrst) begin
      sclPrev_q <= 1'b1;
      sdaPrev_q <= 1'b1;
    end else begin
      sclPrev_q <= sclIn;
      sdaPrev_q <= sdaIn;
    end
  end

  assign sclRise  = sclIn & ~sclPrev_q;
  assign sclFall  = ~sclIn & sclPrev_q;
  assign startDet = sclIn & sclPrev_q & sdaPrev_q & ~sdaIn;
  assign stopDet  = sclIn & sclPrev_q & ~sdaPrev_q & sdaIn;
  assign shiftIn  = {shift_q[6:0], sdaIn};

  ////////////////////////////////////////////////////////////////////////
  // Slave sequencer: address, pointer, then data with auto-increment
  always @* begin
    st_d      = st_q;
    bitCnt_d  = bitCnt_q;
    shift_d   = shift_q;
    ptr_d     = ptr_q;
    drive_d   = drive_q;
    ackNext_d = ackNext_q;
    wrEn      = 1'b0;
    loadNow   = 1'b0;
    if (stopDet) begin
      st_d    = ST_IDLE;
      drive_d = 1'b0;
    end else if (startDet) begin
      st_d     = ST_ADDR;
      bitCnt_d = 3'h0;
      drive_d  = 1'b0;
    end else begin
      case (st_q)
        ST_ADDR, ST_PTR, ST_WDATA: begin
          if (sclRise) begin
            shift_d  = shiftIn;
            bitCnt_d = bitCnt_q + 3'h1;
            if (bitCnt_q == 3'h7) begin
              st_d = ST_ACK;
              case (st_q)
                ST_ADDR: begin
                  // Foreign address: stay off the bus until next start
                  ackNext_d = sdaIn ? ST_RLOAD : ST_PTR;
                  if (shiftIn[7:1] != `CEF_I2C_ADDR) begin
                    st_d = ST_IDLE;
                  end
                end
                ST_PTR: begin
                  ptr_d     = shiftIn;
                  ackNext_d = ST_WDATA;
                end
                default: begin
                  wrEn      = 1'b1;
                  ptr_d     = ptr_q + 8'h01;
                  ackNext_d = ST_WDATA;
                end
              endcase
            end
          end
        end
        ST_ACK: begin
          // First falling edge pulls SDA low; second one releases it, or drives data bit 7 when a read follows
          if (sclFall) begin
            if (!drive_q) begin
              drive_d = 1'b1;
            end else begin
              drive_d  = 1'b0;
              bitCnt_d = 3'h0;
              st_d     = ackNext_q;
              loadNow  = (ackNext_q == ST_RLOAD);
            end
          end
        end
        ST_RDATA: begin
          if (sclFall) begin
            bitCnt_d = bitCnt_q + 3'h1;
            if (bitCnt_q == 3'h7) begin
              drive_d = 1'b0;
              st_d    = ST_RACK;
            end else begin
              shift_d = {shift_q[6:0], 1'b0};
              drive_d = ~shift_q[6];
            end
          end
        end
        ST_RACK: begin
          // Master NACK ends the read burst
          if (sclRise) begin
            st_d = sdaIn ? ST_IDLE : ST_RLOAD;
          end
        end
        ST_RLOAD: begin
          loadNow = sclFall;
        end
        default: begin
          st_d = ST_IDLE;
        end
      endcase
    end
    // Byte capture for a read; this is also the read that clears flags
    if (loadNow) begin
      shift_d  = rdData;
      ptr_d    = ptr_q + 8'h01;
      drive_d  = ~rdData[7];
      bitCnt_d = 3'h0;
      st_d     = ST_RDATA;
    end
  end

  always @(posedge clk) begin
    if (!nrst) begin
      st_q      <= ST_IDLE;
      bitCnt_q  <= 3'h0;
      shift_q   <= 8'h00;
      ptr_q     <= 8'h00;
      drive_q   <= 1'b0;
      ackNext_q <= ST_IDLE;
    end else begin
      st_q      <= st_d;
      bitCnt_q  <= bitCnt_d;
      shift_q   <= shift_d;
      ptr_q     <= ptr_d;
      drive_q   <= drive_d;
      ackNext_q <= ackNext_d;
    end
  end

  // Open-drain SDA: only ever pulled low
  assign sdaOut = 1'b0;
  assign sdaOeN = ~drive_q;

  ////////////////////////////////////////////////////////////////////////
  // Read mux; reserved flag bits read 0, reserved mask bits read 1
  always @* begin
    case (ptr_q)
      `CEF_OFS_ID:     rdData = {REVISION, PART_ID};
      `CEF_OFS_FLAG_A: rdData = flagA;
      `CEF_OFS_FLAG_B: rdData = {flagB[4:3], 3'h0, flagB[2:0]};
      `CEF_OFS_FLAG_C: rdData = {flagC, 6'h00};
      `CEF_OFS_STATE:  rdData = {5'h00, state_q};
      `CEF_OFS_MASK_A: rdData = maskA_q;
      `CEF_OFS_MASK_B: rdData = {maskB_q[4:3], `CEF_RSVD_MB, maskB_q[2:0]};
      `CEF_OFS_MASK_C: rdData = {maskC_q, `CEF_RSVD_MC};
      default:         rdData = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Writable registers; regRst restores all of them to their reset values
  always @(posedge clk) begin
    if (!nrst) begin
      maskA_q <= `CEF_MASK_A_RST;
      maskB_q <= `CEF_MASK_B_RST;
      maskC_q <= `CEF_MASK_C_RST;
      state_q <= `CEF_STATE_RST;
    end else if (regRst) begin
      maskA_q <= `CEF_MASK_A_RST;
      maskB_q <= `CEF_MASK_B_RST;
      maskC_q <= `CEF_MASK_C_RST;
      state_q <= `CEF_STATE_RST;
    end else begin
      if (wrEn) begin
        case (ptr_q)
          `CEF_OFS_STATE:  state_q <= shiftIn[2:0];
          `CEF_OFS_MASK_A: maskA_q <= shiftIn;
          `CEF_OFS_MASK_B: maskB_q <= {shiftIn[7:6], shiftIn[2:0]};
          `CEF_OFS_MASK_C: maskC_q <= shiftIn[7:6];
          default:         maskA_q <= maskA_q;
        endcase
      end
      // Converter core reports last so it overrides a host write
      if (stateLoad) begin
        state_q <= stateIn;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Mode qualification of soft-start faults
  assign halvFwd = (state_q == `CEF_ST_FWD_HALV);
  assign halvRev = (state_q == `CEF_ST_REV_HALV);
  assign bypFwd  = (state_q == `CEF_ST_FWD_BYP);

  // Release only counts once an overtemp has been seen
  always @(posedge clk) begin
    if (!nrst) begin
      otArmed_q <= 1'b0;
    end else if (dieOvertemp) begin
      otArmed_q <= 1'b1;
    end else if (overtempRelease) begin
      otArmed_q <= 1'b0;
    end
  end
  assign relEvt = overtempRelease & otArmed_q & ~dieOvertemp;

  assign evtA[`CEF_A_CONV_OCP]  = converterOvercurrent;
  assign evtA[`CEF_A_FLY_SHORT] = flyingCapShortCheck & (halvFwd | halvRev);
  assign evtA[`CEF_A_OUT_PRES]  = outputPresent;
  assign evtA[`CEF_A_IN_LOW]    = inputTooLow;
  assign evtA[`CEF_A_OUT_SHORT] = outputShort & (halvFwd | bypFwd);
  assign evtA[`CEF_A_WL_PRES]   = wirelessInputPresent;
  assign evtA[`CEF_A_SW_START]  = switchingStarted;
  assign evtA[`CEF_A_IN_PRES]   = inputPresent;
  assign evtB = {inputOvervoltage, outputOvervoltage, relEvt, dieOvertemp, watchdogTimeout};
  assign evtC = {inputOvercurrent, reverseWirelessOvercurrent};

  ////////////////////////////////////////////////////////////////////////
  // Flag banks cleared by the byte capture of their own offset
  cef_flag_bank #(.WIDTH(8)) uBankA (
    .clk       (clk),
    .nrst      (nrst),
    .evt       (evtA),
    .rdClr     (loadNow & (ptr_q == `CEF_OFS_FLAG_A)),
    .regClr    (regRst),
    .regClrSel (`CEF_FLAG_A_REG_CLR),
    .flags     (flagA)
  );

  cef_flag_bank #(.WIDTH(5)) uBankB (
    .clk       (clk),
    .nrst      (nrst),
    .evt       (evtB),
    .rdClr     (loadNow & (ptr_q == `CEF_OFS_FLAG_B)),
    .regClr    (1'b0),
    .regClrSel (5'h00),
    .flags     (flagB)
  );

  cef_flag_bank #(.WIDTH(2)) uBankC (
    .clk       (clk),
    .nrst      (nrst),
    .evt       (evtC),
    .rdClr     (loadNow & (ptr_q == `CEF_OFS_FLAG_C)),
    .regClr    (1'b0),
    .regClrSel (2'h0),
    .flags     (flagC)
  );

  ////////////////////////////////////////////////////////////////////////
  // Interrupt: registered to keep the pin free of decode glitches
  assign pend = |(flagA & ~maskA_q) | |(flagB & ~maskB_q) | |(flagC & ~maskC_q);

  always @(posedge clk) begin
    if (!nrst) begin
      irqN_q <= 1'b1;
    end else begin
      irqN_q <= ~pend;
    end
  end
  assign irqN = irqN_q;

endmodule // cef_event_regs

// file: testbench/cef_host_model.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////
// Host side: bit-level serial master, moves lines on the falling clock edge
module cef_host_model #(
  parameter [6:0] ADDR = 7'h66
) (
  input  wire clk,
  input  wire sdaLine,
  output reg  scl,
  output reg  sda
);
  reg nak;
  // Both lines idle high; the wire is pulled up when released
  initial begin
    scl = 1'b1;
    sda = 1'b1;
    nak = 1'b0;
  end
  task tk;
    repeat (2) @(negedge clk);
  endtask
  // One bit slot; our data only moves while the clock line is low
  task bt(input b, output r);
    begin
      sda = b;
      tk;
      scl = 1'b1;
      tk;
      tk;
      r = sdaLine;
      scl = 1'b0;
      tk;
    end
  endtask
  // Start or repeated start
  task st;
    begin
      sda = 1'b1;
      tk;
      scl = 1'b1;
      tk;
      sda = 1'b0;
      tk;
      scl = 1'b0;
      tk;
    end
  endtask
  task sp;
    begin
      sda = 1'b0;
      tk;
      scl = 1'b1;
      tk;
      sda = 1'b1;
      tk;
    end
  endtask
  // Eight bits most significant first; sending ones releases the line
  task by(input [7:0] d, output [7:0] q);
    integer i;
    reg r;
    begin
      for (i = 7; i >= 0; i = i - 1) begin
        bt(d[i], r);
        q[i] = r;
      end
    end
  endtask
  // Byte out, then the slave's acknowledge slot
  task wb(input [7:0] d);
    reg [7:0] q;
    reg r;
    begin
      by(d, q);
      bt(1'b1, r);
      nak = nak | r;
    end
  endtask
  task wr(input [7:0] ofs, input [7:0] d);
    begin
      st;
      wb({ADDR, 1'b0});
      wb(ofs);
      wb(d);
      sp;
    end
  endtask
  // Single byte read, closed with a not-acknowledge
  task rd(input [7:0] ofs, output [7:0] d);
    reg r;
    begin
      st;
      wb({ADDR, 1'b0});
      wb(ofs);
      st;
      wb({ADDR, 1'b1});
      by(8'hff, d);
      bt(1'b1, r);
      sp;
    end
  endtask
endmodule // cef_host_model

// file: testbench/cef_event_regs_chk.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////
module cef_event_regs_chk (
  input wire clk,
  input wire nrst,
  input wire sclIn,
  input wire sdaIn,
  input wire sdaOut,
  input wire sdaOeN,
  input wire regRst,
  input wire irqN
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  reg [1:0] defCnt_q;
  reg [3:0] hiCnt_q;
  // Masks are known all ones while the port stays quiet after a reset
  always @(posedge clk) begin
    if (!nrst || regRst)
      defCnt_q <= 2'h1;
    else if (!sclIn)
      defCnt_q <= 2'h0;
    else if (defCnt_q == 2'h1 || defCnt_q == 2'h2)
      defCnt_q <= defCnt_q + 2'h1;
  end
  // Clock-high run length; saturates so only a truly idle bus reaches 15
  always @(posedge clk) begin
    if (!nrst || !sclIn)
      hiCnt_q <= 4'h0;
    else if (hiCnt_q != 4'hf)
      hiCnt_q <= hiCnt_q + 4'h1;
  end
  sequence s_stop;
    sclIn && $past(sclIn) && $rose(sdaIn);
  endsequence
  a_reset_idle: assert property ($rose(nrst) |-> irqN && sdaOeN)
    else $error("outputs not idle after reset");
  a_data_zero: assert property (sdaOut == 1'b0)
    else $error("data pin value not low");
  a_drive_after_fall: assert property ($changed(sdaOeN) |-> $past(sclIn, 2) || $past(sclIn, 3))
    else $error("data drive moved away from a clock fall");
  a_hold_while_high: assert property (sclIn |=> $stable(sdaOeN))
    else $error("data drive moved with clock high");
  a_stop_release: assert property (s_stop |=> sdaOeN [*4])
    else $error("data driven after stop");
  a_idle_release: assert property (sclIn [*8] |-> sdaOeN)
    else $error("data driven on idle bus");
  a_mask_default: assert property (defCnt_q == 2'h3 |-> irqN)
    else $error("interrupt through default masks");
  a_irq_holds: assert property (hiCnt_q == 4'hf && !irqN && !regRst && !$past(regRst)
    |=> !irqN)
    else $error("interrupt dropped without a read");
endmodule // cef_event_regs_chk
bind cef_event_regs cef_event_regs_chk i_cef_event_regs_chk (.clk(clk), .nrst(nrst),
  .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOeN(sdaOeN), .regRst(regRst),
  .irqN(irqN));

// file: testbench/testbench.sv
`timescale 1ns/1ps
`include "cef_consts.vh"
module testbench;
  localparam [3:0] REV = 4'h2; // Arbitrary value
  localparam [3:0] PID = 4'h9; // Arbitrary value
  reg         clk = 1'b0;
  reg         nrst = 1'b0;
  reg         regRst = 1'b0;
  reg         stateLoad = 1'b0;
  reg  [2:0]  stateIn = 3'h0;
  reg  [14:0] ev = 15'h0;
  wire        scl;
  wire        mSda;
  wire        sdaOut;
  wire        sdaOeN;
  wire        irqN;
  integer     mismatches = 0;
  integer     n_checks = 0;
  integer     i;
  reg  [7:0]  v;
  reg  [15:0] m;
  // Open-drain wire: low if either side pulls
  wire        sdaIn = mSda & (sdaOeN | sdaOut);
  cef_event_regs #(.REVISION(REV), .PART_ID(PID)) i_cef_event_regs (
    .clk(clk), .nrst(nrst), .sclIn(scl), .sdaIn(sdaIn), .sdaOut(sdaOut),
    .sdaOeN(sdaOeN), .regRst(regRst), .stateLoad(stateLoad), .stateIn(stateIn),
    .converterOvercurrent(ev[7]), .flyingCapShortCheck(ev[6]),
    .outputPresent(ev[5]), .inputTooLow(ev[4]), .outputShort(ev[3]),
    .wirelessInputPresent(ev[2]), .switchingStarted(ev[1]), .inputPresent(ev[0]),
    .inputOvervoltage(ev[8]), .outputOvervoltage(ev[9]), .dieOvertemp(ev[10]),
    .overtempRelease(ev[11]), .watchdogTimeout(ev[12]), .inputOvercurrent(ev[13]),
    .reverseWirelessOvercurrent(ev[14]), .irqN(irqN));
  cef_host_model i_cef_host_model (.clk(clk), .sdaLine(sdaIn), .scl(scl), .sda(mSda));
  always #5 clk = ~clk;
  ////////////////////////////////////////////////////////////
  // Event index to {offset, flag bit}; overtemp comes before its release
  function [15:0] evMap(input integer k);
    case (k)
      8: evMap = 16'h0280;
      9: evMap = 16'h0240;
      10: evMap = 16'h0202;
      11: evMap = 16'h0204;
      12: evMap = 16'h0201;
      13: evMap = 16'h0380;
      14: evMap = 16'h0340;
      default: evMap = {8'h01, 8'h01 << k};
    endcase
  endfunction
  task wt(input integer n);
    repeat (n) @(negedge clk);
  endtask
  task ck(input e, input g);
    begin
      n_checks = n_checks + 1;
      if (g !== e) begin
        mismatches = mismatches + 1;
        $display("BAD irqN exp %b got %b", e, g);
      end
    end
  endtask
  task rc(input [7:0] ofs, input [7:0] e);
    begin
      i_cef_host_model.rd(ofs, v);
      n_checks = n_checks + 1;
      if (v !== e || i_cef_host_model.nak !== 1'b0) begin
        mismatches = mismatches + 1;
        $display("BAD reg %h exp %h got %h", ofs, e, v);
      end
    end
  endtask
  task ld(input [2:0] s);
    begin
      stateIn = s;
      stateLoad = 1'b1;
      wt(1);
      stateLoad = 1'b0;
      wt(1);
    end
  endtask
  task rp;
    begin
      regRst = 1'b1;
      wt(1);
      regRst = 1'b0;
      wt(2);
    end
  endtask
  task conclude;
    begin
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  // Hang guard
  initial begin
    repeat (100000) @(posedge clk);
    mismatches = mismatches + 1;
    conclude;
  end
  ////////////////////////////////////////////////////////////
  initial begin
    wt(2);
    nrst = 1'b1;
    wt(2);
    i_cef_host_model.wr(`CEF_OFS_ID, 8'h00);
    rc(`CEF_OFS_ID, {REV, PID});
    rc(`CEF_OFS_MASK_A, 8'hff);
    rc(`CEF_OFS_MASK_B, 8'hff);
    rc(`CEF_OFS_MASK_C, 8'hff);
    rc(8'h09, 8'h00);
    for (i = 0; i < 7; i = i + 1) begin
      ld(i[2:0]);
      rc(`CEF_OFS_STATE, {5'h0, i[2:0]});
    end
    // Short checks must be ignored while in the fault state
    ev = 15'h0048;
    wt(3);
    ev = 15'h0000;
    rc(`CEF_OFS_FLAG_A, 8'h00);
    // Host write of the state field, then each short check in one of its own modes
    i_cef_host_model.wr(`CEF_OFS_STATE, 8'h04);
    rc(`CEF_OFS_STATE, 8'h04);
    ev = 15'h0048;
    wt(3);
    ev = 15'h0000;
    rc(`CEF_OFS_FLAG_A, 8'h40);
    ld(`CEF_ST_FWD_BYP);
    ev = 15'h0048;
    wt(3);
    ev = 15'h0000;
    rc(`CEF_OFS_FLAG_A, 8'h08);
    // Flag registers ignore host writes
    i_cef_host_model.wr(`CEF_OFS_FLAG_A, 8'hff);
    rc(`CEF_OFS_FLAG_A, 8'h00);
    ld(`CEF_ST_FWD_HALV);
    i_cef_host_model.wr(`CEF_OFS_MASK_A, 8'h00);
    i_cef_host_model.wr(`CEF_OFS_MASK_B, 8'h00);
    i_cef_host_model.wr(`CEF_OFS_MASK_C, 8'h00);
    // Reserved mask bits keep reading as ones
    rc(`CEF_OFS_MASK_B, 8'h38);
    rc(`CEF_OFS_MASK_C, 8'h3f);
    // Each event alone: flag, interrupt, clear on read, interrupt release
    for (i = 0; i < 15; i = i + 1) begin
      m = evMap(i);
      ev[i] = 1'b1;
      wt(3);
      ck(1'b0, irqN);
      rc(m[15:8], m[7:0]);
      rc(m[15:8], 8'h00);
      ck(1'b1, irqN);
      ev[i] = 1'b0;
    end
    // A release with no overtemp since the last one stays silent
    ev[11] = 1'b1;
    wt(3);
    ev[11] = 1'b0;
    ck(1'b1, irqN);
    rc(`CEF_OFS_FLAG_B, 8'h00);
    // Register reset restores masks, then masked events stay silent
    rp;
    ev[1:0] = 2'h3;
    wt(3);
    ck(1'b1, irqN);
    // Mask bits act by position: only the open bit lets its own flag through
    i_cef_host_model.wr(`CEF_OFS_MASK_A, 8'h7f);
    ck(1'b1, irqN);
    i_cef_host_model.wr(`CEF_OFS_MASK_A, 8'hfd);
    ck(1'b0, irqN);
    rp;
    ck(1'b1, irqN);
    rc(`CEF_OFS_FLAG_A, 8'h02);
    rc(`CEF_OFS_STATE, 8'h00);
    rc(`CEF_OFS_MASK_A, 8'hff);
    rc(`CEF_OFS_ID, {REV, PID});
    ev = 15'h0000;
    conclude;
  end
endmodule // testbench
